// *** design/asal_consts.svh ***
// constants for the addressable serial attenuator load link
// assumes inclusion by bare name from package and modules
`ifndef ASAL_CONSTS_SVH
`define ASAL_CONSTS_SVH
`define ASAL_FRAME_BITS      16
`define ASAL_WORD_BITS       8
`define ASAL_LEVEL_BITS      6
`define ASAL_STRAP_BITS      3
`define ASAL_CLK_MHZ         50
`define ASAL_SCLK_MIN_NS     100
`define ASAL_PHASE_MIN_NS    30
`define ASAL_GAP_MIN_NS      10
`define ASAL_PULSE_MIN_NS    30
`define ASAL_PHASE_CYC  ((`ASAL_PHASE_MIN_NS*`ASAL_CLK_MHZ+999)/1000)
`define ASAL_GAP_CYC    ((`ASAL_GAP_MIN_NS*`ASAL_CLK_MHZ+999)/1000)
`define ASAL_PULSE_CYC  ((`ASAL_PULSE_MIN_NS*`ASAL_CLK_MHZ+999)/1000)
`define ASAL_HALF_DEFAULT    5
`define ASAL_POWERUP_LEVEL   6'h3F
`endif

// *** design/asal_pkg.sv ***
// types for the addressable serial attenuator load link
// assumes asal_consts.svh on the include path
`include "asal_consts.svh"
package asal_pkg;
  typedef logic [`ASAL_LEVEL_BITS-1:0] asal_level_t;
  typedef logic [`ASAL_STRAP_BITS-1:0] asal_strap_t;
  typedef logic [`ASAL_FRAME_BITS-1:0] asal_frame_t;
  typedef enum logic [2:0]
  {
    ASAL_IDLE  = 3'b000,
    ASAL_LOW   = 3'b001,
    ASAL_HIGH  = 3'b010,
    ASAL_GAP   = 3'b011,
    ASAL_PULSE = 3'b100,
    ASAL_DONE  = 3'b101
  } asal_host_state_t;
endpackage : asal_pkg

// *** design/asal_link_if.sv ***
// shared serial pins between host and attenuator ends
// assumes the bench resolves level_bit_3 from drive enable
`timescale 1ns/1ps
interface asal_link_if;
  logic load_strobe;
  logic serial_in;
  logic serial_clk;
  logic serial_out;
  logic serial_out_oe;
  modport device (input load_strobe, input serial_in, input serial_clk,
                  output serial_out, output serial_out_oe);
  modport host (output load_strobe, output serial_in, output serial_clk,
                input serial_out, input serial_out_oe);
endinterface : asal_link_if

// *** design/asal_sync.sv ***
// two-flop synchroniser for one pin
// assumes d_i is asynchronous to clock_i
`timescale 1ns/1ps
module asal_sync
(
  input  wire logic clock_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic meta;
  logic next_meta;
  logic next_q;
  always_comb
  begin
    next_meta = ce_i ? d_i : meta;
    next_q    = ce_i ? meta : q_o;
  end
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      meta <= 1'b0;
      q_o  <= 1'b0;
    end
    else
    begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end
endmodule : asal_sync

// *** design/asal_device.sv ***
// attenuator end: shift register, address match and core latch
// assumes host-made serial clock far slower than clock_i
// Function
// - shift one bit per rising clock, strobe low
// - strobe rise copies register into core
// - sixteen clocks: level byte then address, lsb first
// - serial out repeats input sixteen clocks later
// - host serial clock at most 10 MHz
// - host clock phases each at least 30 ns
// - host waits 10 ns before strobe rise
// - host strobe pulse at least 30 ns high
// - level bits 1..3 share serial pins; this device has no parallel mode, so the pins carry serial data only
// - level bits 4..6 share address straps; here the straps only set the address
// - update core only on address match
// - host sends four times dB, spare bits low
// - mode 0: sample rising, output on falling
// - host keeps strobe low while shifting
`timescale 1ns/1ps
`include "asal_consts.svh"
module asal_device
  import asal_pkg::*;
(
  input  wire logic               clock_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  asal_link_if.device             link,
  input  wire asal_pkg::asal_strap_t select_strap_i,
  output asal_pkg::asal_level_t   level_o,
  output logic                    match_o
);
  import asal_pkg::*;
  logic        strobe_s;
  logic        sclk_s;
  logic        sdin_s;
  logic        strobe_d;
  logic        sclk_d;
  asal_frame_t shift;
  asal_strap_t strap_m;
  asal_strap_t strap_q;
  logic        oe_q;
  logic        next_oe;
  logic        out_bit;
  asal_frame_t next_shift;
  asal_level_t next_level;
  logic        next_match;
  logic        next_out;
  logic        rise_clk;
  logic        fall_clk;
  logic        rise_strobe;
  logic        addr_hit;
  asal_sync u_sync_le (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
                       .d_i(link.load_strobe), .q_o(strobe_s));
  asal_sync u_sync_ck (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
                       .d_i(link.serial_clk), .q_o(sclk_s));
  asal_sync u_sync_di (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce_i),
                       .d_i(link.serial_in), .q_o(sdin_s));
  always_comb
  begin
    rise_clk    = sclk_s & ~sclk_d;
    fall_clk    = ~sclk_s & sclk_d;
    rise_strobe = strobe_s & ~strobe_d;
    // address byte sits in the upper half, lsb first
    addr_hit = (shift[`ASAL_FRAME_BITS-1 -: `ASAL_WORD_BITS] ==
                {5'h00, strap_q});
    next_shift = shift;
    next_level = level_o;
    next_match = match_o;
    next_out   = out_bit;
    // serial mode only, so the shared pin is ours from the first enabled clock after reset
    next_oe    = 1'b1;
    if (rise_clk && !strobe_s)
      next_shift = {sdin_s, shift[`ASAL_FRAME_BITS-1:1]};
    if (fall_clk)
      next_out = shift[0];
    if (rise_strobe)
    begin
      next_match = addr_hit;
      if (addr_hit)
        next_level = shift[`ASAL_LEVEL_BITS:1];
    end
  end
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      strobe_d <= 1'b0;
      sclk_d   <= 1'b0;
      shift    <= '0;
      level_o  <= `ASAL_POWERUP_LEVEL;
      match_o  <= 1'b0;
      out_bit  <= 1'b0;
      strap_m  <= '0;
      strap_q  <= '0;
      oe_q     <= 1'b0;
    end
    else if (ce_i)
    begin
      strobe_d <= strobe_s;
      sclk_d   <= sclk_s;
      shift    <= next_shift;
      level_o  <= next_level;
      match_o  <= next_match;
      out_bit  <= next_out;
      // straps are pins too: two flops before the compare
      strap_m  <= select_strap_i;
      strap_q  <= strap_m;
      oe_q     <= next_oe;
    end
  end
  assign link.serial_out    = out_bit;
  assign link.serial_out_oe = oe_q;
endmodule : asal_device

// *** design/asal_host.sv ***
// host end: builds and shifts one addressed frame, then strobes
// assumes the device end samples the pins with its own clock
`timescale 1ns/1ps
`include "asal_consts.svh"
module asal_host
  import asal_pkg::*;
#(
  parameter int HALF_CYC = `ASAL_HALF_DEFAULT
)
(
  input  wire logic                  clock_i,
  input  wire logic                  rst_i,
  input  wire logic                  ce_i,
  asal_link_if.host                  link,
  input  wire logic                  start_i,
  input  wire asal_pkg::asal_level_t level_i,
  input  wire asal_pkg::asal_strap_t addr_i,
  output logic                       busy_o,
  output logic                       done_o
);
  import asal_pkg::*;
  asal_host_state_t state;
  asal_host_state_t next_state;
  asal_frame_t      frame;
  asal_frame_t      next_frame;
  logic [4:0]       bits;
  logic [4:0]       next_bits;
  logic [7:0]       cnt;
  logic [7:0]       next_cnt;
  logic             sclk;
  logic             next_sclk;
  logic             strobe;
  logic             next_strobe;
  logic             next_busy;
  logic             next_done;
  localparam logic [7:0] HALF  = 8'(HALF_CYC);
  localparam logic [7:0] GAP   = 8'(`ASAL_GAP_CYC);
  localparam logic [7:0] PULSE = 8'(`ASAL_PULSE_CYC);
  always_comb
  begin
    next_state  = state;
    next_frame  = frame;
    next_bits   = bits;
    next_cnt    = cnt;
    next_sclk   = sclk;
    next_strobe = strobe;
    next_busy   = busy_o;
    next_done   = 1'b0;
    case (state)
      ASAL_IDLE:
      begin
        if (start_i)
        begin
          // level byte is 4x dB: level bits land at 1..6
          next_frame = {5'h00, addr_i, 1'b0, level_i, 1'b0};
          next_bits  = 5'd0;
          next_cnt   = 8'd0;
          next_busy  = 1'b1;
          next_state = ASAL_LOW;
        end
      end
      ASAL_LOW:
      begin
        next_cnt = cnt + 8'd1;
        if (cnt + 8'd1 >= HALF)
        begin
          next_cnt   = 8'd0;
          next_sclk  = 1'b1;
          next_state = ASAL_HIGH;
        end
      end
      ASAL_HIGH:
      begin
        next_cnt = cnt + 8'd1;
        if (cnt + 8'd1 >= HALF)
        begin
          next_cnt   = 8'd0;
          next_sclk  = 1'b0;
          next_frame = {1'b0, frame[`ASAL_FRAME_BITS-1:1]};
          next_bits  = bits + 5'd1;
          if (bits == 5'(`ASAL_FRAME_BITS - 1))
            next_state = ASAL_GAP;
          else
            next_state = ASAL_LOW;
        end
      end
      ASAL_GAP:
      begin
        next_cnt = cnt + 8'd1;
        if (cnt + 8'd1 >= GAP + HALF)
        begin
          next_cnt    = 8'd0;
          next_strobe = 1'b1;
          next_state  = ASAL_PULSE;
        end
      end
      ASAL_PULSE:
      begin
        next_cnt = cnt + 8'd1;
        if (cnt + 8'd1 >= PULSE + HALF)
        begin
          next_cnt    = 8'd0;
          next_strobe = 1'b0;
          next_state  = ASAL_DONE;
        end
      end
      ASAL_DONE:
      begin
        next_busy  = 1'b0;
        next_done  = 1'b1;
        next_state = ASAL_IDLE;
      end
      default:
        next_state = ASAL_IDLE;
    endcase
  end
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state  <= ASAL_IDLE;
      frame  <= '0;
      bits   <= 5'd0;
      cnt    <= 8'd0;
      sclk   <= 1'b0;
      strobe <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      state  <= next_state;
      frame  <= next_frame;
      bits   <= next_bits;
      cnt    <= next_cnt;
      sclk   <= next_sclk;
      strobe <= next_strobe;
      busy_o <= next_busy;
      done_o <= next_done;
    end
  end
  assign link.serial_clk  = sclk;
  assign link.load_strobe = strobe;
  assign link.serial_in   = frame[0];
endmodule : asal_host

// *** dv/asal_link_properties.sv ***
// checker for the serial attenuator load link
// assumes the bench instantiates it beside the link interface
`timescale 1ns/1ps
module asal_link_properties
(
  input wire logic                  clock_i,
  input wire logic                  rst_i,
  input wire logic                  strobe_i,
  input wire logic                  sclk_i,
  input wire logic                  sdata_i,
  input wire logic                  sout_i,
  input wire logic                  sout_oe_i,
  input wire asal_pkg::asal_level_t level_i,
  input wire logic                  match_i
);
  import asal_pkg::*;
  logic [4:0] rises;
  logic [4:0] next_rises;
  logic       clk_q;
  logic       next_clk_q;
  // rising serial clocks since the strobe last fell
  always_comb
  begin
    next_clk_q = sclk_i;
    next_rises = rises;
    if (strobe_i)
      next_rises = 5'h00;
    else if (sclk_i && !clk_q)
      next_rises = rises + 5'h01;
  end
  always_ff @(posedge clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rises <= 5'h00;
      clk_q <= 1'b0;
    end
    else
    begin
      rises <= next_rises;
      clk_q <= next_clk_q;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  a_frame_len: assert property (
    $rose(strobe_i) |-> rises == 5'h10)
    else $error("frame clock count wrong");
  a_shift_low: assert property (
    $rose(sclk_i) |-> !strobe_i)
    else $error("clock rose with strobe high");
  a_period_min: assert property (
    $rose(sclk_i) |=> (!$rose(sclk_i))[*4])
    else $error("serial clock period short");
  a_phase_high: assert property (
    $rose(sclk_i) |-> sclk_i[*2])
    else $error("clock high phase short");
  a_phase_low: assert property (
    $fell(sclk_i) |-> (!sclk_i)[*2])
    else $error("clock low phase short");
  a_strobe_gap: assert property (
    $rose(strobe_i) |-> !$past(sclk_i))
    else $error("strobe too close to clock");
  a_strobe_pulse: assert property (
    $rose(strobe_i) |-> strobe_i[*2])
    else $error("strobe pulse short");
  a_out_on_fall: assert property (
    $changed(sout_i) |-> !sclk_i)
    else $error("serial out moved in high phase");
  a_out_driven: assert property (
    $rose(sclk_i) |-> sout_oe_i)
    else $error("serial out not driven while shifting");
  // rises holds the index of the bit taken at this rise
  a_spare_low: assert property (
    $rose(sclk_i) &&
    (rises == 5'h00 || rises == 5'h07 || rises >= 5'h0B) |-> !sdata_i)
    else $error("spare frame bit not low");
  a_core_holds: assert property (
    $changed(level_i) |-> $past(strobe_i, 3) || $past(strobe_i, 4))
    else $error("level moved without strobe");
  a_change_matched: assert property (
    $changed(level_i) |-> match_i)
    else $error("level moved without match");
  c_strobe: cover property ($rose(strobe_i));
  c_level: cover property ($changed(level_i));
  c_echo: cover property ($rose(sout_i));
  c_refused: cover property ($rose(strobe_i) ##4 !match_i);
endmodule : asal_link_properties

// *** dv/addressable_serial_attenuator_load_tb.sv ***
// bench: host end drives device end over the shared link
// assumes design files compiled first
`timescale 1ns/1ps
module addressable_serial_attenuator_load_tb;
  import asal_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_i   = 1'b1;
  logic        start_i = 1'b0;
  asal_level_t level_i = 6'h00;
  asal_strap_t addr_i  = 3'h0;
  asal_strap_t strap   = 3'h5;
  asal_level_t level_o;
  logic        match_o;
  logic        busy_o;
  logic        done_o;
  logic        ce      = 1'b1;
  int          n_errors = 0;
  int          n_tests  = 0;
  int          nbit     = 16;
  logic [15:0] exp_frame;
  logic        hist[$];
  always #10 clock_i = ~clock_i;
  asal_link_if i_asal_link_if ();
  asal_host i_asal_host (.clock_i(clock_i), .rst_i(rst_i), .ce_i(ce),
    .link(i_asal_link_if), .start_i(start_i), .level_i(level_i),
    .addr_i(addr_i), .busy_o(busy_o), .done_o(done_o));
  asal_device i_asal_device (.clock_i(clock_i), .rst_i(rst_i),
    .ce_i(ce), .link(i_asal_link_if), .select_strap_i(strap),
    .level_o(level_o), .match_o(match_o));
  asal_link_properties i_asal_link_properties (.clock_i(clock_i),
    .rst_i(rst_i), .strobe_i(i_asal_link_if.load_strobe),
    .sclk_i(i_asal_link_if.serial_clk),
    .sdata_i(i_asal_link_if.serial_in),
    .sout_i(i_asal_link_if.serial_out),
    .sout_oe_i(i_asal_link_if.serial_out_oe),
    .level_i(level_o), .match_i(match_o));
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic conclude();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude
  // wire watch; echo checked across frames, shift never resets
  always @(posedge i_asal_link_if.serial_clk)
  begin
    if (nbit < 16)
      chk("serial_in", {7'h00, exp_frame[nbit]},
          {7'h00, i_asal_link_if.serial_in});
    nbit++;
    if (hist.size() >= 16)
      chk("serial_out", {7'h00, hist[hist.size()-16]},
          {7'h00, i_asal_link_if.serial_out});
    hist.push_back(i_asal_link_if.serial_in);
  end
  task automatic send(input asal_level_t lv, input asal_strap_t ad,
                      input asal_level_t el, input logic em);
    int i;
    @(negedge clock_i);
    level_i = lv;
    addr_i = ad;
    start_i = 1'b1;
    exp_frame = {5'h00, ad, 1'b0, lv, 1'b0};
    nbit = 0;
    @(negedge clock_i);
    start_i = 1'b0;
    chk("busy_o", 8'h01, {7'h00, busy_o});
    for (i = 0; i < 400 && done_o !== 1'b1; i++)
      @(negedge clock_i);
    if (i == 400)
    begin
      n_errors++;
      conclude();
    end
    chk("busy_o end", 8'h00, {7'h00, busy_o});
    chk("level_o", {2'h0, el}, {2'h0, level_o});
    chk("match_o", {7'h00, em}, {7'h00, match_o});
  endtask : send
  task automatic t_reset();
    chk("reset level", 8'h3F, {2'h0, level_o});
    chk("reset match", 8'h00, {7'h00, match_o});
  endtask : t_reset
  task automatic t_match();
    send(6'h25, 3'h5, 6'h25, 1'b1);
  endtask : t_match
  task automatic t_mismatch();
    send(6'h0A, 3'h2, 6'h25, 1'b0);
  endtask : t_mismatch
  task automatic t_extremes();
    send(6'h00, 3'h5, 6'h00, 1'b1);
    send(6'h3F, 3'h5, 6'h3F, 1'b1);
  endtask : t_extremes
  task automatic t_strap();
    strap = 3'h2;
    send(6'h1C, 3'h2, 6'h1C, 1'b1);
  endtask : t_strap
  // both ends frozen mid-frame; the serial clock must stand still
  task automatic t_freeze();
    logic ck;
    fork
      send(6'h15, 3'h2, 6'h15, 1'b1);
      begin
        repeat (40) @(negedge clock_i);
        ce = 1'b0;
        ck = i_asal_link_if.serial_clk;
        repeat (7) @(negedge clock_i);
        chk("frozen clk", {7'h00, ck},
            {7'h00, i_asal_link_if.serial_clk});
        ce = 1'b1;
      end
    join
  endtask : t_freeze
  initial
  begin
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    rst_i = 1'b0;
    t_reset();
    t_match();
    t_mismatch();
    t_extremes();
    t_strap();
    t_freeze();
    conclude();
  end
endmodule : addressable_serial_attenuator_load_tb
